// file: rtl/dao_pkg.sv
// Shared constants for the dual converter output and mode control block.
// Assumes one 40 MHz system clock and AXI4-Lite register access.
package dao_pkg;

  localparam int SAMPLE_W   = 8;
  localparam int COARSE_W   = 5;
  localparam int FINE_W     = 4;
  localparam int PIPE_DEPTH = 4;
  localparam int AXI_ADDR_W = 8;

  // Sample-clock cycles that software should discard after leaving standby
  localparam logic [3:0] RECOVERY_CYCLES = 4'hF;

  localparam logic [AXI_ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] DATA_OFS   = 8'h08;

  localparam int  CTRL_CAPTURE_BIT = 0;
  localparam logic CTRL_CAPTURE_RST = 1'b0;

  localparam int ST_A_ACTIVE   = 0;
  localparam int ST_B_ACTIVE   = 1;
  localparam int ST_A_RECOVER  = 2;
  localparam int ST_B_RECOVER  = 3;
  localparam int ST_ALIGN      = 4;
  localparam int ST_FORMAT     = 5;
  localparam int ST_OVERRUN    = 6;
  localparam int ST_LEVEL_LSB  = 8;
  localparam int DATA_VALID_BIT = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Encoding follows {mode_select_hi, mode_select_lo}
  typedef enum logic [1:0] {
    MODE_STANDBY_BOTH,
    MODE_STANDBY_B,
    MODE_NORMAL,
    MODE_ALIGN
  } dao_mode_e;

endpackage

// file: rtl/dao_adc_ctrl.sv
// Output staging, format and mode control of a dual 8-bit pipelined converter.
// Assumes sample clocks well below a third of aclk; all converter-side pins pass two flops.
//
// Rules this block is written against
// R1 - Output sample equals input taken four sample-clock rising edges earlier
// R2 - Output of a channel changes only after its own sample-clock rising edge
// R3 - format_select high gives twos complement, low gives offset binary
// R4 - Mode pins: 00 both standby, 01 B standby, 10 normal, 11 aligned
// R5 - In standby the channel's outputs float and its sample clock is ignored
// R6 - Reference stays on in full standby; single standby affects channel B only
// R7 - Receiver discards fifteen sample-clock cycles after standby ends
// R8 - Alignment delays channel B output by half a sample-clock cycle
// R9 - Clocks in antiphase with alignment: B output appears at A's rising edge
// R10 - Shared clock with alignment: B output lags A by half a cycle
// R11 - Shared clock without alignment: both outputs update on the same edge
// R12 - Sample clocks must run at one mega-sample per second or faster
// R13 - Code built from five coarse bits and four-bit flash with correction
// R14 - Each channel gets its own sample clock, possibly from one source
// R15 - Twos complement code is offset binary with its top bit inverted
// R16 - During channel B standby, channel A runs with unchanged timing
`timescale 1ns/10ps
module dao_adc_ctrl
  import dao_pkg::*;
#(
  parameter int FIFO_WIDTH = 2 * SAMPLE_W,
  parameter int FIFO_DEPTH = 2
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  chan_a_sample_clock,
  input  wire logic                  chan_b_sample_clock,
  input  wire logic                  format_select,
  input  wire logic                  mode_select_hi,
  input  wire logic                  mode_select_lo,
  input  wire logic [COARSE_W-1:0]   chan_a_coarse,
  input  wire logic [FINE_W-1:0]     chan_a_fine,
  input  wire logic [COARSE_W-1:0]   chan_b_coarse,
  input  wire logic [FINE_W-1:0]     chan_b_fine,
  output wire logic [SAMPLE_W-1:0]   chan_a_sample_out,
  output wire logic                  chan_a_out_oe_n,
  output wire logic [SAMPLE_W-1:0]   chan_b_sample_out,
  output wire logic                  chan_b_out_oe_n,
  output wire logic                  ref_active,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output wire logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output wire logic                  s_axi_wready,
  output wire logic [1:0]            s_axi_bresp,
  output wire logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output wire logic                  s_axi_arready,
  output wire logic [31:0]           s_axi_rdata,
  output wire logic [1:0]            s_axi_rresp,
  output wire logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int SYNC_W = 5 + 2 * (COARSE_W + FINE_W);
  localparam int PW     = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW     = $clog2(FIFO_DEPTH + 1);

  function automatic logic [SAMPLE_W-1:0] fmt_code(input logic [SAMPLE_W-1:0] c,
                                                   input logic twos);
    fmt_code = twos ? {~c[SAMPLE_W-1], c[SAMPLE_W-2:0]} : c;  // [R3] [R15]
  endfunction

  // Overlap bit of the flash carries into the coarse field; overflow saturates
  function automatic logic [SAMPLE_W-1:0] correct(input logic [COARSE_W-1:0] co,
                                                  input logic [FINE_W-1:0] fi);
    logic [SAMPLE_W:0] sum;
    sum = {1'b0, co, 3'h0} + {5'h00, fi[3], 3'h0} + {6'h00, fi[2:0]};  // [R13]
    correct = sum[SAMPLE_W] ? 8'hFF : sum[SAMPLE_W-1:0];
  endfunction

  // Pin synchroniser; the second stage and the edge history are the only readers
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [1:0]        clk_prev_reg;
  logic [1:0]        clk_s;
  logic              fmt_s;
  logic              hi_s;
  logic              lo_s;
  logic [COARSE_W-1:0] coarse_s [2];
  logic [FINE_W-1:0]   fine_s [2];
  dao_mode_e         mode;
  logic              align_s;
  logic [1:0]        chan_on;

  assign {clk_s, fmt_s, hi_s, lo_s, fine_s[1], coarse_s[1], fine_s[0], coarse_s[0]} = sync2_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      clk_prev_reg <= 2'h0;
    end else begin
      sync1_reg    <= {chan_b_sample_clock, chan_a_sample_clock, format_select,
                       mode_select_hi, mode_select_lo, chan_b_fine, chan_b_coarse,
                       chan_a_fine, chan_a_coarse};
      sync2_reg    <= sync1_reg;
      clk_prev_reg <= clk_s;
    end
  end

  assign mode       = dao_mode_e'({hi_s, lo_s});
  assign align_s    = (mode == MODE_ALIGN);                                   // [R4]
  assign chan_on[0] = (mode != MODE_STANDBY_BOTH);                           // [R4] [R16]
  assign chan_on[1] = (mode == MODE_NORMAL) || (mode == MODE_ALIGN);         // [R4] [R6]

  // Per-channel pipeline, output register and standby handling
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic                rise;
    logic                fall;
    logic                on;
    logic [SAMPLE_W-1:0] pipe_reg  [PIPE_DEPTH];
    logic [SAMPLE_W-1:0] pipe_next [PIPE_DEPTH];
    logic [SAMPLE_W-1:0] hold_reg,  hold_next;
    logic [SAMPLE_W-1:0] out_reg,   out_next;
    logic                oe_n_reg,  oe_n_next;
    logic                load_reg,  load_next;
    logic                on_prev_reg, on_prev_next;
    logic [3:0]          rec_reg,   rec_next;

    assign rise = clk_s[ch] & ~clk_prev_reg[ch];
    assign fall = ~clk_s[ch] & clk_prev_reg[ch];
    assign on   = chan_on[ch];

    always_comb begin
      pipe_next    = pipe_reg;
      hold_next    = hold_reg;
      out_next     = out_reg;
      load_next    = 1'b0;
      oe_n_next    = ~on;                                                    // [R5]
      on_prev_next = on;
      rec_next     = rec_reg;
      // A standby channel ignores its clock, so the pipeline freezes
      if (on && rise) begin                                                  // [R5]
        pipe_next[0] = correct(coarse_s[ch], fine_s[ch]);                    // [R13]
        for (int i = 1; i < PIPE_DEPTH; i++) begin
          pipe_next[i] = pipe_reg[i-1];                                      // [R1]
        end
        hold_next = fmt_code(pipe_reg[PIPE_DEPTH-1], fmt_s);
      end
      if ((ch == 1) && align_s) begin
        // Falling edge of B sits half a cycle after its rising edge
        if (on && fall) begin                                                // [R8] [R9] [R10]
          out_next  = hold_reg;
          load_next = 1'b1;
        end
      end else if (on && rise) begin                                         // [R2] [R11]
        out_next  = fmt_code(pipe_reg[PIPE_DEPTH-1], fmt_s);                 // [R1] [R3]
        load_next = 1'b1;
      end
      if (on && !on_prev_reg) begin
        rec_next = RECOVERY_CYCLES;
      end else if (on && rise && (rec_reg != 4'h0)) begin
        rec_next = rec_reg - 4'h1;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        for (int i = 0; i < PIPE_DEPTH; i++) begin
          pipe_reg[i] <= 8'h00;
        end
        hold_reg    <= 8'h00;
        out_reg     <= 8'h00;
        oe_n_reg    <= 1'b1;
        load_reg    <= 1'b0;
        on_prev_reg <= 1'b0;
        rec_reg     <= 4'h0;
      end else begin
        pipe_reg    <= pipe_next;
        hold_reg    <= hold_next;
        out_reg     <= out_next;
        oe_n_reg    <= oe_n_next;
        load_reg    <= load_next;
        on_prev_reg <= on_prev_next;
        rec_reg     <= rec_next;
      end
    end
  end

  assign chan_a_sample_out = g_ch[0].out_reg;
  assign chan_a_out_oe_n   = g_ch[0].oe_n_reg;
  assign chan_b_sample_out = g_ch[1].out_reg;
  assign chan_b_out_oe_n   = g_ch[1].oe_n_reg;

  logic ref_active_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_active_reg <= 1'b0;
    end else begin
      ref_active_reg <= 1'b1;                                                // [R6]
    end
  end
  assign ref_active = ref_active_reg;

  // Two-entry capture buffer: pairs land when channel A updates
  logic [FIFO_WIDTH-1:0] mem_reg [FIFO_DEPTH];
  logic [FIFO_WIDTH-1:0] mem_next [FIFO_DEPTH];
  logic [PW-1:0]         wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]         rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0]         count_reg,  count_next;
  logic                  push_valid;
  logic                  push_ready;
  logic                  pop_valid;
  logic                  pop_ready;
  logic                  cap_en_reg;

  assign push_valid = g_ch[0].load_reg & cap_en_reg;
  assign push_ready = (count_reg != CW'(FIFO_DEPTH));
  assign pop_valid  = (count_reg != '0);

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push_valid && push_ready) begin
      mem_next[wr_ptr_reg] = {chan_b_sample_out, chan_a_sample_out};
      wr_ptr_next = (wr_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
    end
    if (pop_valid && pop_ready) begin
      rd_ptr_next = (rd_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
    end
    count_next = count_reg + CW'(push_valid && push_ready) - CW'(pop_valid && pop_ready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  logic                  awready_reg, awready_next;
  logic                  wready_reg,  wready_next;
  logic                  bvalid_reg,  bvalid_next;
  logic [1:0]            bresp_reg,   bresp_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg,  rvalid_next;
  logic [1:0]            rresp_reg,   rresp_next;
  logic [31:0]           rdata_reg,   rdata_next;
  logic [AXI_ADDR_W-1:0] awaddr_reg,  awaddr_next;
  logic [31:0]           wdata_reg,   wdata_next;
  logic [3:0]            wstrb_reg,   wstrb_next;
  logic                  cap_en_next;
  logic                  ovr_reg,     ovr_next;
  logic [31:0]           status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_A_ACTIVE]  = chan_on[0];
    status_word[ST_B_ACTIVE]  = chan_on[1];
    status_word[ST_A_RECOVER] = (g_ch[0].rec_reg != 4'h0);
    status_word[ST_B_RECOVER] = (g_ch[1].rec_reg != 4'h0);
    status_word[ST_ALIGN]     = align_s;
    status_word[ST_FORMAT]    = fmt_s;
    status_word[ST_OVERRUN]   = ovr_reg;
    status_word[ST_LEVEL_LSB +: CW] = count_reg;
  end

  always_comb begin
    logic clr_ovr;
    clr_ovr      = 1'b0;
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    cap_en_next  = cap_en_reg;
    pop_ready    = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      awready_next = 1'b0;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      wready_next = 1'b0;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (!awready_reg && !wready_reg && !bvalid_reg) begin
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (awaddr_reg == CTRL_OFS) begin
        if (wstrb_reg[0]) cap_en_next = wdata_reg[CTRL_CAPTURE_BIT];
      end else if (awaddr_reg == STATUS_OFS) begin
        clr_ovr = wstrb_reg[0] & wdata_reg[ST_OVERRUN];
      end else begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      if (s_axi_araddr == CTRL_OFS) begin
        rdata_next[CTRL_CAPTURE_BIT] = cap_en_reg;
      end else if (s_axi_araddr == STATUS_OFS) begin
        rdata_next = status_word;
      end else if (s_axi_araddr == DATA_OFS) begin
        // Reading the data word pops it; an empty buffer reads with valid low
        rdata_next[DATA_VALID_BIT]  = pop_valid;
        rdata_next[FIFO_WIDTH-1:0]  = pop_valid ? mem_reg[rd_ptr_reg] : '0;
        pop_ready = 1'b1;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    // A lost pair in the same cycle as the clear keeps the flag set
    ovr_next = (ovr_reg && !clr_ovr) || (push_valid && !push_ready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      cap_en_reg  <= CTRL_CAPTURE_RST;
      ovr_reg     <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      cap_en_reg  <= cap_en_next;
      ovr_reg     <= ovr_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  a_pipe_depth: assert property (@(posedge aclk) disable iff (!aresetn)  // [R1]
    (g_ch[0].on && g_ch[0].rise) |=> ##1
      (g_ch[0].pipe_reg[3] == $past(g_ch[0].pipe_reg[2], 2)) || !$past(g_ch[0].on))
    else $error("channel A pipeline did not advance one stage");
  a_out_after_edge: assert property (@(posedge aclk) disable iff (!aresetn)  // [R2]
    $changed(chan_a_sample_out) |-> $past(g_ch[0].rise) && $past(g_ch[0].on))
    else $error("channel A output changed without a sample-clock rising edge");
  a_fmt_code: assert property (@(posedge aclk) disable iff (!aresetn)  // [R3] [R15]
    (g_ch[0].on && g_ch[0].rise) |=>
      (chan_a_sample_out[SAMPLE_W-2:0] == $past(g_ch[0].pipe_reg[3][SAMPLE_W-2:0])) &&
      (chan_a_sample_out[SAMPLE_W-1] ==
        ($past(g_ch[0].pipe_reg[3][SAMPLE_W-1]) ^ $past(fmt_s))))
    else $error("channel A output format wrong");
  a_both_standby: assert property (@(posedge aclk) disable iff (!aresetn)  // [R5]
    (!hi_s && !lo_s) |=> chan_a_out_oe_n && chan_b_out_oe_n)
    else $error("outputs driven in full standby");
  a_b_standby: assert property (@(posedge aclk) disable iff (!aresetn)  // [R6]
    (!hi_s && lo_s) |=> !chan_a_out_oe_n && chan_b_out_oe_n && ref_active)
    else $error("single standby not limited to channel B");
  a_a_keeps_running: assert property (@(posedge aclk) disable iff (!aresetn)  // [R16]
    (!hi_s && lo_s && g_ch[0].rise) |=> g_ch[0].load_reg && !g_ch[1].load_reg)
    else $error("channel A stalled during channel B standby");
  a_align_half: assert property (@(posedge aclk) disable iff (!aresetn)  // [R8]
    (align_s && g_ch[1].fall) |=> chan_b_sample_out == $past(g_ch[1].hold_reg))
    else $error("aligned channel B output not taken at its falling edge");
  a_align_rise_quiet: assert property (@(posedge aclk) disable iff (!aresetn)  // [R10]
    (align_s && g_ch[1].rise) |=> $stable(chan_b_sample_out))
    else $error("aligned channel B output moved on its rising edge");
  a_same_edge: assert property (@(posedge aclk) disable iff (!aresetn)  // [R11]
    (hi_s && !lo_s && g_ch[0].rise && g_ch[1].rise) |=> g_ch[0].load_reg && g_ch[1].load_reg)
    else $error("unaligned channels did not update together");
  a_code_saturate: assert property (@(posedge aclk) disable iff (!aresetn)  // [R13]
    (chan_on[0] && g_ch[0].rise && (coarse_s[0] == 5'h1F) && fine_s[0][3]) |=>
      g_ch[0].pipe_reg[0] == 8'hFF)
    else $error("corrected code did not saturate");

endmodule // dao_adc_ctrl

// file: test/dao_cap_model.sv
// Far-side model: one clock source feeding both sample clock pins, raw stage codes.
// Assumes aclk at 40 MHz; sample clocks are derived from it, ten aclk per period.
`timescale 1ns/10ps
module dao_cap_model
  import dao_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                antiphase,
  output logic [3:0]               ph,
  output logic                     chan_a_sample_clock,
  output logic                     chan_b_sample_clock,
  output logic [COARSE_W-1:0]      chan_a_coarse,
  output logic [FINE_W-1:0]        chan_a_fine,
  output logic [COARSE_W-1:0]      chan_b_coarse,
  output logic [FINE_W-1:0]        chan_b_fine
);
  // Reset alone starts ph and the step count; both clocks are held low until then
  logic [7:0] step_reg;

  // Codes move at phase 7, far from both rising edges, so the design samples them settled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph       <= 4'h0;
      step_reg <= 8'h00;
    end else begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h6) begin
        step_reg <= step_reg + 8'h01;
      end
    end
  end

  // Four mega-samples per second, high and low five aclk each
  assign chan_a_sample_clock = aresetn && (ph < 4'h5);
  assign chan_b_sample_clock = aresetn && (antiphase ? (ph >= 4'h5) : (ph < 4'h5));

  // Saturating and carry cases both occur as the step counter wraps
  assign chan_a_coarse = step_reg[4:0];
  assign chan_a_fine   = step_reg[3:0] ^ 4'h5;
  assign chan_b_coarse = ~step_reg[4:0];
  assign chan_b_fine   = step_reg[7:4];
endmodule // dao_cap_model

// file: test/dao_adc_ctrl_tb.sv
// Self-checking bench: sample outputs against a latency model, registers over AXI4-Lite.
// Assumes dao_pkg and the capture model; a 20000 cycle ceiling cuts a hang short.
`timescale 1ns/10ps
module dao_adc_ctrl_tb
  import dao_pkg::*;
;
  logic        aclk, aresetn, antiphase, format_select, mode_select_hi, mode_select_lo;
  logic        chan_a_sample_clock, chan_b_sample_clock, chan_a_out_oe_n, chan_b_out_oe_n;
  logic        ref_active, fmt, pa, pb;
  logic [3:0]  ph, chan_a_fine, chan_b_fine, s_axi_wstrb;
  logic [4:0]  chan_a_coarse, chan_b_coarse;
  logic [7:0]  chan_a_sample_out, chan_b_sample_out, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  ha[$], hb[$];
  int          num_errors, n_tests, cycles, quiet;

  dao_adc_ctrl dut_u (
    .aclk, .aresetn, .chan_a_sample_clock, .chan_b_sample_clock, .format_select,
    .mode_select_hi, .mode_select_lo, .chan_a_coarse, .chan_a_fine, .chan_b_coarse,
    .chan_b_fine, .chan_a_sample_out, .chan_a_out_oe_n, .chan_b_sample_out,
    .chan_b_out_oe_n, .ref_active, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  dao_cap_model cap_u (
    .aclk, .aresetn, .antiphase, .ph, .chan_a_sample_clock, .chan_b_sample_clock,
    .chan_a_coarse, .chan_a_fine, .chan_b_coarse, .chan_b_fine);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [7:0] cv(input logic [4:0] c, input logic [3:0] f);
    logic [8:0] s;
    s = {1'b0, c, 3'b000} + {5'h00, f[3], 3'b000} + {6'h00, f[2:0]};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic [7:0] fx(input logic [7:0] v);
    return fmt ? {~v[7], v[6:0]} : v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] mk,
                      input logic [31:0] e);
    logic [31:0] d;
    axr(a, RESP_OKAY, d);
    chk(nm, e, d & mk);
  endtask

  // Pins change at phase 2 so they settle well before the next rising edge
  task automatic pins(input logic [1:0] m, input logic f);
    do @(posedge aclk); while (ph != 4'h1);
    mode_select_hi <= m[1];
    mode_select_lo <= m[0];
    format_select  <= f;
    mode  = m;
    fmt   = f;
    quiet = 2;
    ha.delete();
    hb.delete();
  endtask

  task automatic wp(input int n);
    repeat (n * 10) @(posedge aclk);
  endtask

  // Monitor samples on the falling aclk edge, where every output has settled
  always @(negedge aclk) begin
    cycles++;
    if (aresetn && chan_a_sample_clock && !pa && mode != MODE_STANDBY_BOTH)
      ha.push_back(cv(chan_a_coarse, chan_a_fine));
    if (aresetn && chan_b_sample_clock && !pb && mode[1])
      hb.push_back(cv(chan_b_coarse, chan_b_fine));
    pa = chan_a_sample_clock;
    pb = chan_b_sample_clock;
    if (aresetn && ph == 4'h6) begin
      if (quiet > 0) quiet--;
      else begin
        chk("oe_a", 32'(mode == MODE_STANDBY_BOTH), 32'(chan_a_out_oe_n));
        chk("oe_b", 32'(!mode[1]), 32'(chan_b_out_oe_n));
        chk("ref", 32'h0000_0001, 32'(ref_active));
        if (ha.size() > 5)
          chk("out_a", 32'(fx(ha[ha.size()-5])), 32'(chan_a_sample_out));
        if (hb.size() > 6)
          chk("out_b", 32'(fx(hb[hb.size()-(mode == MODE_ALIGN ? 6 : 5)])),
              32'(chan_b_sample_out));
      end
    end
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  mm;
    logic        ff;
    aresetn = 1'b0;
    antiphase = 1'b0;
    format_select = 1'b0;
    mode_select_hi = 1'b1;
    mode_select_lo = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {fmt, pa, pb, mode, quiet, num_errors, n_tests, cycles} = '0;
    mode = 2'b10;
    quiet = 2;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl_rst", CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      mm = i[1:0];
      ff = i[2];
      pins(mm, ff);
      wp(20);
      rchk("status", STATUS_OFS, 32'h0000_0333,
           {26'h0, ff, mm == 2'b11, 2'b00, mm[1], mm != 2'b00});
      $display("test mode %0d format %0d done", mm, ff);
    end
    pins(2'b01, 1'b0);
    wp(10);
    pins(2'b10, 1'b0);
    wp(2);
    rchk("recovering", STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
    wp(15);
    rchk("recovered", STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
    $display("test recovery done");
    pins(2'b11, 1'b0);
    // Switch while B is high in both phasings, so its pin shows no short pulse
    do @(posedge aclk); while (ph != 4'h4);
    antiphase <= 1'b1;
    wp(20);
    $display("test antiphase align done");
    axw(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    rchk("ctrl_on", CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    wp(5);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    rchk("full", STATUS_OFS, 32'h0000_0340, 32'h0000_0240);
    rchk("pop1", DATA_OFS, 32'h0001_0000, 32'h0001_0000);
    rchk("pop2", DATA_OFS, 32'h0001_0000, 32'h0001_0000);
    rchk("empty", DATA_OFS, 32'h0001_0000, 32'h0000_0000);
    axw(STATUS_OFS, 32'h0000_0040, RESP_OKAY);
    rchk("ovr_clr", STATUS_OFS, 32'h0000_0340, 32'h0000_0000);
    axw(8'h0C, 32'h0000_0001, RESP_SLVERR);
    axr(8'h0C, RESP_SLVERR, d);
    chk("unmapped", 32'h0000_0000, d);
    rchk("ctrl_kept", CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test buffer and registers done");
    wrap_up();
  end
endmodule // dao_adc_ctrl_tb
